// File: logic/vmsl_params.svh
// Purpose: Constants for the margin, slew and loop scale command registers.
// Assumes: 125 MHz clock; linear words decoded with 16 fraction bits.
// Notes: Definitions only.
`ifndef VMSL_PARAMS_SVH
`define VMSL_PARAMS_SVH
// Command codes of the three word registers.
`define CMD_MARGIN_LOW 8'h26
`define CMD_SLEW_RATE 8'h27
`define CMD_LOOP_SCALE 8'h29
// Reset exponents.
`define SLEW_EXP_RST 5'h1c
`define SCALE_EXP_RST 5'h19
// Decoded slew range, 0.067 and 15.933 mV/us in Q16.
`define SLEW_MIN_Q 48'sh0000_0000_1127
`define SLEW_MAX_Q 48'sh0000_000f_eed9
// Decoded loop scale range and divider thresholds in Q16.
`define SCALE_MIN_Q 48'sh0000_0000_0001
`define SCALE_MAX_Q 48'sh0000_0001_0000
`define SCALE_Q_0125 48'sh0000_0000_2000
`define SCALE_Q_025 48'sh0000_0000_4000
`define SCALE_Q_05 48'sh0000_0000_8000
// Slew code is in 1/16 mV/us: Q16 shifted by 12, rounded.
`define SLEW_CODE_SHIFT 12
`define SLEW_ROUND_Q 48'sh0000_0000_0800
// Margin plus trim ceiling per divider, in output LSBs.
`define MLIM_DIV1 18'sh00166
`define MLIM_DIV05 18'sh002cd
`define MLIM_DIV025 18'sh00599
`define MLIM_DIV0125 18'sh00c00
// Operation margin field value for margin low.
`define MARGIN_SEL_LOW 2'h1
// Rate tick: 1 us of 8 ns cycles.
`define TICK_TIME_NS 1000
`define CLK_PERIOD_NS 8
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`endif

// File: logic/vmsl_pkg.sv
// Purpose: Types for the margin, slew and loop scale command registers.
// Assumes: Used with vmsl_params.svh.
// Notes: Types only.
`default_nettype none
package vmsl_pkg;
  // Internal feedback divider settings.
  typedef enum logic [1:0] {DIV_1, DIV_05, DIV_025, DIV_0125} divider_t;
endpackage : vmsl_pkg
`default_nettype wire

// File: logic/vout_margin_slew_scale_regs.sv
// Purpose: Margin low target, slew rate and loop scale word registers.
// Assumes: Word commands arrive as synchronous strobes from a bus front end.
// Notes: Nonvolatile values are caught in the first cycle after reset.
// Summary of operation
// - Margin low goal is margin plus trim.
// - Margin entry and exit ramp at slew.
// - Margin value unsigned, relative or absolute.
// - Invalid writes set status and notify host.
// - Conversion voltage changes use programmed slew.
// - Turn on and off ramps skip slew.
// - Slew word exponent resets minus four.
// - Slew stored exactly, nearest rate applied.
// - Slew valid 0.067 to 15.933 mV/us.
// - Scale exponent resets 11001b, mantissa nonvolatile.
// - Scale maps command and selects divider.
// - Scale quantized to four divider factors.
// - Every in-range scale value reads back.
// - Scale hardware blocked while converting, except on restore.
// - Reference scaling uses actual programmed scale.
// - Limit violations clamp; warning raised only while converting.
`timescale 1ns/1ns
`default_nettype none
`include "vmsl_params.svh"
module vout_margin_slew_scale_regs
  import vmsl_pkg::*;
#(
  parameter logic [9:0] LSB_SIXTEENTHS = 10'h01f
) (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // Word command port.
  input wire logic CMD_VALID_IN,
  input wire logic CMD_WRITE_IN,
  input wire logic [7:0] CMD_CODE_IN,
  input wire logic [15:0] CMD_WDATA_IN,
  input wire logic CLEAR_FAULTS_IN,
  // Nonvolatile reset values.
  input wire logic [15:0] NVM_MARGIN_LOW_IN,
  input wire logic [10:0] NVM_SLEW_MAN_IN,
  input wire logic [10:0] NVM_SCALE_MAN_IN,
  input wire logic NVM_RESTORE_IN,
  // Converter context.
  input wire logic CONV_EN_IN,
  input wire logic RAMP_ONOFF_IN,
  input wire logic [1:0] MARGIN_SEL_IN,
  input wire logic VOUT_MODE_REL_IN,
  input wire logic [15:0] VOUT_COMMAND_IN,
  input wire logic [15:0] VOUT_TRIM_IN,
  input wire logic [15:0] VOUT_MAX_IN,
  input wire logic [15:0] VOUT_MIN_IN,
  // Read answer.
  output logic RD_VALID_OUT,
  output logic [15:0] RD_DATA_OUT,
  // Status.
  output logic CML_FLAG_OUT,
  output logic VOUT_WARN_OUT,
  output logic ALERT_OUT,
  // Hardware settings.
  output logic [15:0] TARGET_OUT,
  output logic [7:0] SLEW_CODE_OUT,
  output logic [1:0] DIVIDER_OUT,
  output logic [15:0] REF_SCALE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Linear word decoding.

  // Decodes a linear word into Q16 fixed point.
  function automatic logic signed [47:0] lin_dec(input logic [15:0] w);
    logic signed [47:0] m;
    logic [5:0] sh;
    m = {{37{w[10]}}, w[10:0]};
    sh = 6'({w[15], w[15:11]} + 6'h10);
    return m <<< sh;
  endfunction : lin_dec

  // Quantizes a decoded scale to a divider setting.
  function automatic divider_t div_of(input logic signed [47:0] q);
    if (q <= `SCALE_Q_0125) begin
      return DIV_0125;
    end else if (q <= `SCALE_Q_025) begin
      return DIV_025;
    end else if (q <= `SCALE_Q_05) begin
      return DIV_05;
    end else begin
      return DIV_1;
    end
  endfunction : div_of

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode.

  logic [15:0] margin_low_target_q; // Margin low word.
  logic [15:0] output_slew_rate_q; // Slew rate word.
  logic [15:0] loop_scale_factor_q; // Loop scale word.
  logic nvm_load_q; // High for the cycle after reset.
  logic cml_q; // Invalid data flag.
  logic warn_q; // Limit warning flag.
  logic [15:0] target_q; // Ramped output target.
  logic [9:0] acc_q; // Slew accumulator in 1/16 mV.
  logic [7:0] tick_cnt_q; // Microsecond divider.
  logic tick_q; // One cycle per microsecond.
  divider_t div_q; // Applied divider.

  logic wr; // Write strobe.
  logic rd; // Read strobe.
  logic signed [47:0] wr_dec; // Decoded write data.
  logic signed [17:0] trim_s; // Signed trim.
  logic signed [17:0] wr_margin; // Margin write goal.
  logic signed [17:0] mlim; // Margin ceiling.
  logic bad_write; // Write refused.
  logic signed [17:0] goal_raw; // Unclamped goal.
  logic [15:0] goal; // Clamped goal.
  logic clamp; // Goal hit a limit.
  logic [7:0] slew_code; // Nearest supported rate.
  logic [10:0] acc_sum; // Accumulator plus tick.

  assign wr = CMD_VALID_IN & CMD_WRITE_IN & ~nvm_load_q;
  assign rd = CMD_VALID_IN & ~CMD_WRITE_IN & ~nvm_load_q;
  assign wr_dec = lin_dec(CMD_WDATA_IN);
  assign trim_s = {{2{VOUT_TRIM_IN[15]}}, VOUT_TRIM_IN};

  // Ceiling follows the divider in use.
  always_comb begin
    case (div_q)
      DIV_1: mlim = `MLIM_DIV1;
      DIV_05: mlim = `MLIM_DIV05;
      DIV_025: mlim = `MLIM_DIV025;
      default: mlim = `MLIM_DIV0125;
    endcase
  end

  // Margin value is unsigned; relative mode offsets the command.
  assign wr_margin = 18'({2'h0, CMD_WDATA_IN} + trim_s +
    (VOUT_MODE_REL_IN ? {2'h0, VOUT_COMMAND_IN} : 18'sh0));

  // Checks each write against its valid span.
  always_comb begin
    bad_write = 1'b0;
    if (wr) begin
      case (CMD_CODE_IN)
        `CMD_MARGIN_LOW: bad_write = (wr_margin < 0) || (wr_margin > mlim);
        `CMD_SLEW_RATE: bad_write = (wr_dec < `SLEW_MIN_Q) || (wr_dec > `SLEW_MAX_Q);
        `CMD_LOOP_SCALE: bad_write = (wr_dec < `SCALE_MIN_Q) ||
          (wr_dec > `SCALE_MAX_Q);
        default: bad_write = 1'b1; // Unsupported command.
      endcase
    end
  end

  // Reset load, then accepted writes store the word unchanged.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      nvm_load_q <= 1'b1;
      margin_low_target_q <= 16'h0000;
      output_slew_rate_q <= {`SLEW_EXP_RST, 11'h000};
      loop_scale_factor_q <= {`SCALE_EXP_RST, 11'h000};
    end else if (nvm_load_q) begin
      nvm_load_q <= 1'b0;
      margin_low_target_q <= NVM_MARGIN_LOW_IN;
      output_slew_rate_q <= {`SLEW_EXP_RST, NVM_SLEW_MAN_IN};
      loop_scale_factor_q <= {`SCALE_EXP_RST, NVM_SCALE_MAN_IN};
    end else if (wr && !bad_write) begin
      case (CMD_CODE_IN)
        `CMD_MARGIN_LOW: margin_low_target_q <= CMD_WDATA_IN;
        `CMD_SLEW_RATE: output_slew_rate_q <= CMD_WDATA_IN;
        default: loop_scale_factor_q <= CMD_WDATA_IN;
      endcase
    end
  end

  // Read answers one cycle after the request.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      RD_VALID_OUT <= 1'b0;
      RD_DATA_OUT <= 16'h0000;
    end else begin
      RD_VALID_OUT <= rd;
      if (rd) begin
        case (CMD_CODE_IN)
          `CMD_MARGIN_LOW: RD_DATA_OUT <= margin_low_target_q;
          `CMD_SLEW_RATE: RD_DATA_OUT <= output_slew_rate_q;
          `CMD_LOOP_SCALE: RD_DATA_OUT <= loop_scale_factor_q;
          default: RD_DATA_OUT <= 16'h0000; // Unknown code reads zero.
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a set in the clear cycle wins.

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      cml_q <= 1'b0;
      warn_q <= 1'b0;
      ALERT_OUT <= 1'b0;
    end else begin
      cml_q <= bad_write | (cml_q & ~CLEAR_FAULTS_IN);
      warn_q <= (clamp & CONV_EN_IN) | (warn_q & ~CLEAR_FAULTS_IN);
      ALERT_OUT <= cml_q | warn_q;
    end
  end

  assign CML_FLAG_OUT = cml_q;
  assign VOUT_WARN_OUT = warn_q;

  ////////////////////////////////////////////////////////////////////////////
  // Loop scale hardware setting.

  // Divider follows the register only while conversion is off or on restore.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      div_q <= DIV_1;
      REF_SCALE_OUT <= 16'h0000;
    end else if (!CONV_EN_IN || NVM_RESTORE_IN) begin
      div_q <= div_of(lin_dec(loop_scale_factor_q));
      REF_SCALE_OUT <= loop_scale_factor_q;
    end
  end

  assign DIVIDER_OUT = div_q;

  ////////////////////////////////////////////////////////////////////////////
  // Goal selection and limit clamp.

  always_comb begin
    if (MARGIN_SEL_IN == `MARGIN_SEL_LOW) begin
      goal_raw = 18'({2'h0, margin_low_target_q} + trim_s +
        (VOUT_MODE_REL_IN ? {2'h0, VOUT_COMMAND_IN} : 18'sh0));
    end else begin
      goal_raw = 18'({2'h0, VOUT_COMMAND_IN} + trim_s);
    end
    clamp = 1'b1;
    if (goal_raw > $signed({2'h0, VOUT_MAX_IN})) begin
      goal = VOUT_MAX_IN;
    end else if (goal_raw < $signed({2'h0, VOUT_MIN_IN})) begin
      goal = VOUT_MIN_IN;
    end else begin
      goal = goal_raw[15:0];
      clamp = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slew rate ramp.

  // Nearest supported rate in 1/16 mV/us.
  assign slew_code = 8'((lin_dec(output_slew_rate_q) + `SLEW_ROUND_Q) >>> `SLEW_CODE_SHIFT);
  assign acc_sum = {1'b0, acc_q} + (tick_q ? {3'h0, slew_code} : 11'h000);

  // Microsecond tick from the clock.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || tick_cnt_q == 8'(`TICK_CYCLES - 1)) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
    tick_q <= NRST_IN && tick_cnt_q == 8'(`TICK_CYCLES - 1);
  end

  // Target steps one LSB per LSB_SIXTEENTHS of accumulated rate.
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      target_q <= 16'h0000;
      acc_q <= 10'h000;
      SLEW_CODE_OUT <= 8'h00;
    end else begin
      SLEW_CODE_OUT <= slew_code;
      if (RAMP_ONOFF_IN || !CONV_EN_IN) begin
        target_q <= goal;
        acc_q <= 10'h000;
      end else if (target_q == goal) begin
        acc_q <= 10'h000;
      end else if (acc_sum >= {1'b0, LSB_SIXTEENTHS}) begin
        target_q <= (target_q < goal) ? target_q + 16'h0001 : target_q - 16'h0001;
        acc_q <= 10'(acc_sum - {1'b0, LSB_SIXTEENTHS});
      end else begin
        acc_q <= acc_sum[9:0];
      end
    end
  end

  assign TARGET_OUT = target_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_MARGIN_GOAL: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (MARGIN_SEL_IN == `MARGIN_SEL_LOW) && !VOUT_MODE_REL_IN && !clamp |->
      goal == 16'(margin_low_target_q + VOUT_TRIM_IN)) else $error("margin goal wrong");
  AST_ONOFF_JUMP: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    RAMP_ONOFF_IN |=> target_q == $past(goal)) else $error("on off ramp slewed");
  AST_RAMP_STEP: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    CONV_EN_IN && $past(CONV_EN_IN) && !RAMP_ONOFF_IN && !$past(RAMP_ONOFF_IN) |->
      (target_q - $past(target_q) <= 16'h0001) ||
      ($past(target_q) - target_q <= 16'h0001)) else $error("ramp step too big");
  AST_SLEW_RESET: assert property (@(posedge CLK_IN)
    !NRST_IN ##1 NRST_IN |-> output_slew_rate_q[15:11] == `SLEW_EXP_RST)
    else $error("slew exponent reset wrong");
  AST_SCALE_RESET: assert property (@(posedge CLK_IN)
    !NRST_IN ##1 NRST_IN ##1 1'b1 |-> loop_scale_factor_q[15:11] == `SCALE_EXP_RST)
    else $error("scale exponent reset wrong");
  AST_BAD_FLAG: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    bad_write |=> cml_q ##1 ALERT_OUT) else $error("invalid write not flagged");
  AST_BAD_KEEP: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    bad_write && CMD_CODE_IN == `CMD_SLEW_RATE |=> $stable(output_slew_rate_q))
    else $error("invalid slew stored");
  AST_SCALE_BLOCK: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    CONV_EN_IN && !NVM_RESTORE_IN |=> $stable(div_q) && $stable(REF_SCALE_OUT))
    else $error("divider changed while converting");
  AST_READBACK: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    wr && !bad_write && CMD_CODE_IN == `CMD_LOOP_SCALE |=>
      loop_scale_factor_q == $past(CMD_WDATA_IN)) else $error("scale write not stored");
  AST_READ_DATA: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    rd && CMD_CODE_IN == `CMD_LOOP_SCALE |=>
      RD_VALID_OUT && RD_DATA_OUT == $past(loop_scale_factor_q))
    else $error("scale readback differs");
  AST_CLAMP_WARN: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    clamp && CONV_EN_IN |=> warn_q ##1 ALERT_OUT) else $error("limit warning missing");

endmodule : vout_margin_slew_scale_regs
`default_nettype wire

// File: testbench/pmbus_host_model.sv
// Purpose: Host model that issues word commands to the command registers.
// Assumes: One command at a time, driven after the falling clock edge.
// Notes: Idle command lines carry inverted values so stale data never looks valid.
`timescale 1ns/1ns
`default_nettype none
module pmbus_host_model (
  // Clock and read answer.
  input wire logic clk_in,
  input wire logic rd_valid_in,
  input wire logic [15:0] rd_data_in,
  // Command strobes.
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic [7:0] cmd_code_out,
  output logic [15:0] cmd_wdata_out,
  output logic restore_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero.
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out = 8'hff;
    cmd_wdata_out = 16'hffff;
    restore_out = 1'b0;
  end
  // One word transfer; the strobe stands for one cycle only.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rdat, output logic got);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_write_out = wr;
    cmd_code_out = code;
    cmd_wdata_out = data;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_write_out = ~wr;
    cmd_code_out = ~code;
    cmd_wdata_out = ~data;
    got = rd_valid_in;
    rdat = rd_data_in;
  endtask : xfer
  // One-cycle restore pulse, which applies a pending loop scale.
  task automatic restore();
    @(negedge clk_in);
    restore_out = 1'b1;
    @(negedge clk_in);
    restore_out = 1'b0;
  endtask : restore
endmodule : pmbus_host_model
`default_nettype wire

// File: testbench/vout_margin_slew_scale_regs_tb.sv
// Purpose: Self-checking bench for the margin, slew and loop scale registers.
// Assumes: Host model drives the command port; bench drives converter context.
// Notes: Random slew mantissas come from a fixed seed.
`timescale 1ns/1ns
`default_nettype none
`include "vmsl_params.svh"
module vout_margin_slew_scale_regs_tb;
  import vmsl_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, clr = 1'b0, conv = 1'b0, onoff = 1'b0, rel = 1'b0;
  logic [1:0] msel = 2'h1;
  logic [15:0] cmd = 16'h0000, trim = 16'h0000, vmax = 16'hffff, vmin = 16'h0000;
  logic [10:0] nslew = 11'h010;
  logic cv, cw, rst_req, rdv, cml, warn, alert, got;
  logic [7:0] cc, slew;
  logic [15:0] cd, rdd, tgt, refs, r;
  logic [1:0] div;
  int error_cnt = 0, checks_done = 0, m, n;
  divider_t dexp[7] = '{DIV_0125, DIV_025, DIV_025, DIV_05, DIV_05, DIV_1, DIV_1};
  int mans[7] = '{16, 17, 32, 33, 64, 65, 128};
  vout_margin_slew_scale_regs i_vout_margin_slew_scale_regs (.CLK_IN(clk), .NRST_IN(nrst),
    .CMD_VALID_IN(cv), .CMD_WRITE_IN(cw), .CMD_CODE_IN(cc), .CMD_WDATA_IN(cd),
    .CLEAR_FAULTS_IN(clr), .NVM_MARGIN_LOW_IN(16'h0064), .NVM_SLEW_MAN_IN(nslew),
    .NVM_SCALE_MAN_IN(11'h040), .NVM_RESTORE_IN(rst_req), .CONV_EN_IN(conv),
    .RAMP_ONOFF_IN(onoff), .MARGIN_SEL_IN(msel), .VOUT_MODE_REL_IN(rel),
    .VOUT_COMMAND_IN(cmd), .VOUT_TRIM_IN(trim), .VOUT_MAX_IN(vmax), .VOUT_MIN_IN(vmin),
    .RD_VALID_OUT(rdv), .RD_DATA_OUT(rdd), .CML_FLAG_OUT(cml), .VOUT_WARN_OUT(warn),
    .ALERT_OUT(alert), .TARGET_OUT(tgt), .SLEW_CODE_OUT(slew), .DIVIDER_OUT(div),
    .REF_SCALE_OUT(refs));
  pmbus_host_model i_pmbus_host_model (.clk_in(clk), .rd_valid_in(rdv), .rd_data_in(rdd),
    .cmd_valid_out(cv), .cmd_write_out(cw), .cmd_code_out(cc), .cmd_wdata_out(cd),
    .restore_out(rst_req));
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 8 ns period.
  initial begin
    forever #4 clk = ~clk;
  end
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Reads one register and compares the word and the answer strobe.
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    i_pmbus_host_model.xfer(1'b0, code, 16'h0000, r, got);
    chk("rd_valid", {15'h0, got}, 16'h0001);
    chk("rd_data", r, exp);
  endtask : rd
  // Writes one register and checks the invalid-data flag.
  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic bad);
    i_pmbus_host_model.xfer(1'b1, code, data, r, got);
    chk("cml", {15'h0, cml}, {15'h0, bad});
  endtask : wr
  // Clears sticky flags for one cycle.
  task automatic clear();
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
  endtask : clear
  // Waits a bounded time for the target to reach a value.
  task automatic wait_tgt(input logic [15:0] v);
    n = 0;
    while (tgt !== v && n < 4000) begin
      @(negedge clk) n++;
    end
  endtask : wait_tgt
  // Prints counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // Watchdog that cuts a hung run short.
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(18));
    nslew = 11'(2 + $urandom % 253);
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    rd(`CMD_MARGIN_LOW, 16'h0064);
    rd(`CMD_SLEW_RATE, {5'h1c, nslew});
    rd(`CMD_LOOP_SCALE, 16'hc840);
    chk("div_reset", {14'h0, div}, {14'h0, DIV_05});
    rd(8'h28, 16'h0000);
    chk("cml_unk_read", {15'h0, cml}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 2 : (i == 1) ? 254 : 2 + $urandom % 253;
      wr(`CMD_SLEW_RATE, {5'h1c, 11'(m)}, 1'b0);
      rd(`CMD_SLEW_RATE, {5'h1c, 11'(m)});
      chk("slew_code", {8'h0, slew}, 16'(m));
    end
    wr(`CMD_SLEW_RATE, 16'he001, 1'b1);
    @(negedge clk) chk("alert", {15'h0, alert}, 16'h0001);
    clear();
    wr(`CMD_SLEW_RATE, 16'he0ff, 1'b1);
    rd(`CMD_SLEW_RATE, {5'h1c, 11'(m)});
    clear();
    for (int i = 0; i < 7; i++) begin
      wr(`CMD_LOOP_SCALE, {5'h19, 11'(mans[i])}, 1'b0);
      @(negedge clk) chk("divider", {14'h0, div}, {14'h0, dexp[i]});
      chk("ref_scale", refs, {5'h19, 11'(mans[i])});
    end
    wr(`CMD_LOOP_SCALE, 16'hc881, 1'b1);
    clear();
    wr(`CMD_LOOP_SCALE, 16'hc800, 1'b1);
    clear();
    rd(`CMD_LOOP_SCALE, 16'hc880);
    conv = 1'b1;
    wr(`CMD_LOOP_SCALE, 16'hc810, 1'b0);
    repeat (2) @(negedge clk);
    chk("div_frozen", {14'h0, div}, {14'h0, DIV_1});
    rd(`CMD_LOOP_SCALE, 16'hc810);
    i_pmbus_host_model.restore();
    @(negedge clk) chk("div_restore", {14'h0, div}, {14'h0, DIV_0125});
    wr(`CMD_LOOP_SCALE, 16'hc880, 1'b0);
    i_pmbus_host_model.restore();
    conv = 1'b0;
    wr(`CMD_MARGIN_LOW, 16'd200, 1'b0);
    @(negedge clk) chk("target_margin", tgt, 16'd200);
    wr(`CMD_MARGIN_LOW, 16'd400, 1'b1);
    rd(`CMD_MARGIN_LOW, 16'd200);
    clear();
    rel = 1'b1;
    cmd = 16'd100;
    wr(`CMD_MARGIN_LOW, 16'd50, 1'b0);
    @(negedge clk) chk("target_rel", tgt, 16'd150);
    rel = 1'b0;
    wr(`CMD_MARGIN_LOW, 16'd200, 1'b0);
    wr(`CMD_SLEW_RATE, 16'he010, 1'b0);
    conv = 1'b1;
    trim = 16'd10;
    repeat (5) @(negedge clk);
    chk("target_slewing", tgt, 16'd200);
    wait_tgt(16'd210);
    chk("target_ramped", tgt, 16'd210);
    chk("ramp_time", 16'(n > 1000), 16'h0001);
    onoff = 1'b1;
    trim = 16'd0;
    repeat (2) @(negedge clk);
    chk("target_onoff", tgt, 16'd200);
    onoff = 1'b0;
    vmax = 16'd205;
    trim = 16'd10;
    repeat (2) @(negedge clk);
    chk("warn", {15'h0, warn}, 16'h0001);
    wait_tgt(16'd205);
    chk("target_clamp", tgt, 16'd205);
    // Leaving margin low ramps back to command plus trim.
    msel = 2'h0;
    cmd = 16'd193;
    repeat (5) @(negedge clk);
    chk("target_leave", tgt, 16'd205);
    wait_tgt(16'd203);
    chk("target_command", tgt, 16'd203);
    stop_test();
  end
endmodule : vout_margin_slew_scale_regs_tb
`default_nettype wire
